/* common/scc_consts.svh */
// Constants for the serial port clock, configuration and status block.
// Assumes inclusion by bare name from design and bench files.
`ifndef SCC_CONSTS_SVH
`define SCC_CONSTS_SVH

// Special function register addresses
`define SCC_ADDR_CFG 8'ha1
`define SCC_ADDR_CTRL 8'hf8
`define SCC_ADDR_CKR 8'ha2
`define SCC_ADDR_DAT 8'ha3

// Configuration and status fields
`define SCC_CFG_BUSY 7
`define SCC_CFG_MASTER_ENABLE 6
`define SCC_CFG_CPHA 5
`define SCC_CFG_CPOL 4
`define SCC_CFG_SLAVE_SELECTED 3
`define SCC_CFG_PINRAW 2
`define SCC_CFG_SREMPTY 1
`define SCC_CFG_RXEMPTY 0

// Control fields
`define SCC_CTL_DONE 7
`define SCC_CTL_WCOL 6
`define SCC_CTL_MODF 5
`define SCC_CTL_OVR 4
`define SCC_CTL_SSM_HI 3
`define SCC_CTL_SSM_LO 2
`define SCC_CTL_TXEMPTY 1
`define SCC_CTL_EN 0

// Reset values
`define SCC_RST_CFG 8'h07
`define SCC_RST_CTRL 8'h06
`define SCC_RST_CKR 8'h00
`define SCC_RST_SSM 2'h1

// Timing
`define SCC_CORE_HZ 20000000
`define SCC_MAX_MASTER_HZ 12500000
`define SCC_MIN_HALF ((`SCC_CORE_HZ + 2 * `SCC_MAX_MASTER_HZ - 1) / (2 * `SCC_MAX_MASTER_HZ))
`define SCC_LAST_BIT 3'h7

`endif

/* common/scc_pkg.sv */
// Types for the serial port clock, configuration and status block.
// Assumes the constants header is on the include path.
package scc_pkg;
  typedef logic [7:0] scc_byte_t;
  typedef enum logic {
    SCC_M_IDLE = 1'b0,
    SCC_M_RUN = 1'b1
  } scc_mst_e;
endpackage

/* common/scc_clk_if.sv */
// Link between the port core and its master clock generator.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface scc_clk_if;
  logic run;
  logic [7:0] div;
  logic cpol;
  logic lead;
  logic trail;
  logic sample;
  logic sck;
  modport gen (input run, input div, input cpol, output lead, output trail, output sample,
    output sck);
  modport core (output run, output div, output cpol, input lead, input trail,
    input sample, input sck);
endinterface

/* verilog/scc_sckgen.sv */
// Master serial clock generator: programmable half period and edge pulses.
// Assumes a single core clock and synchronous active-low reset.
`timescale 1ns/1ps
`include "scc_consts.svh"
module scc_sckgen (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Core side
  scc_clk_if.gen lnk
);
  import scc_pkg::*;

  localparam logic [8:0] MIN_HALF = 9'(`SCC_MIN_HALF);

  logic [8:0] cnt_q;
  logic half_sel_q;
  logic sck_q;
  logic [8:0] req_half;
  logic [8:0] half;
  logic edge_hit;

  assign req_half = {1'b0, lnk.div} + 9'h001;
  assign half = (req_half < MIN_HALF) ? MIN_HALF : req_half;
  assign edge_hit = lnk.run && (cnt_q == half - 9'h001);
  assign lnk.lead = edge_hit && !half_sel_q;
  assign lnk.trail = edge_hit && half_sel_q;
  assign lnk.sample = (half == 9'h001) ? lnk.lead :
    (lnk.run && half_sel_q && (cnt_q == half - 9'h002));
  assign lnk.sck = sck_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !lnk.run) begin
      cnt_q <= 9'h000;
      half_sel_q <= 1'b0;
      sck_q <= rst_n_i ? lnk.cpol : 1'b0;
    end else if (edge_hit) begin
      cnt_q <= 9'h000;
      half_sel_q <= !half_sel_q;
      sck_q <= !sck_q;
    end else begin
      cnt_q <= cnt_q + 9'h001;
    end
  end

  a_bit_period_min: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    lnk.trail |=> !lnk.trail) else $error("bit period below two core cycles");
  a_sample_before_end: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    lnk.sample |=> lnk.trail) else $error("sample not one cycle before bit end");
  a_sck_idle_level: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !lnk.run && $past(!lnk.run) |-> sck_q == $past(lnk.cpol)) else $error("idle level");
endmodule // scc_sckgen

/* verilog/scc_top.sv */
// Serial port core with clock phase and polarity, config and status register.
// Assumes a special-function register port on the core clock; pins are async.
`timescale 1ns/1ps
`include "scc_consts.svh"
module scc_top (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // Register port
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic SFR_WE_I,
  input wire logic SFR_RE_I,
  input wire scc_pkg::scc_byte_t SFR_WDATA_I,
  output scc_pkg::scc_byte_t SFR_RDATA_O,
  // Serial clock pin
  input wire logic SCK_I,
  output logic SCK_O,
  output logic SCK_OE_N_O,
  // Data pins
  input wire logic MOSI_I,
  output logic MOSI_O,
  output logic MOSI_OE_N_O,
  input wire logic MISO_I,
  output logic MISO_O,
  output logic MISO_OE_N_O,
  // Select pin
  input wire logic NSS_I,
  output logic NSS_O,
  output logic NSS_OE_N_O
);
  import scc_pkg::*;

  scc_clk_if lnk ();

  // Control and configuration state
  logic master_enable_q, clock_phase_sel_q, clock_polarity_sel_q, port_enable_q;
  logic [1:0] select_mode_q;
  scc_byte_t clock_divider_value_q;
  logic done_q, wcol_q, modf_q, ovr_q;
  // Datapath state
  scc_byte_t txbuf_q, rxbuf_q, txsh_q, rxsh_q, rdata_q;
  logic tx_full_q, rx_full_q, sh_full_q, shift_reg_empty_q, out_q;
  logic [2:0] bitcnt_q;
  scc_mst_e mst_state_q;
  // Pin sampling
  logic [3:0] meta_q, sync_q;
  logic sck_prev_q, nss_prev_q, nss_flt_q;
  logic [1:0] nss_hist_q;

  logic wr_cfg, wr_ctrl, wr_ckr, wr_dat, rd_dat;
  logic sck_s, mosi_s, miso_s, nss_s, master, sl_en, modf_set;
  logic s_edge, s_lead, s_trail, lead_ev, trail_ev, smp_ev, in_bit;
  logic m_load, s_load, load, active, done, busy, nss_fell;
  scc_byte_t rx_word, cfg_rd, ctrl_rd, rdata_d;

  // Register decode
  assign wr_cfg = SFR_WE_I && (SFR_ADDR_I == `SCC_ADDR_CFG);
  assign wr_ctrl = SFR_WE_I && (SFR_ADDR_I == `SCC_ADDR_CTRL);
  assign wr_ckr = SFR_WE_I && (SFR_ADDR_I == `SCC_ADDR_CKR);
  assign wr_dat = SFR_WE_I && (SFR_ADDR_I == `SCC_ADDR_DAT);
  assign rd_dat = SFR_RE_I && (SFR_ADDR_I == `SCC_ADDR_DAT);

  // Two-stage pin synchronisers
  for (genvar i = 0; i < 4; i++) begin : g_sync
    localparam logic RV = (i == 3) ? 1'b1 : 1'b0;
    always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
        meta_q[i] <= RV;
        sync_q[i] <= RV;
      end else begin
        meta_q[i] <= (i == 0) ? SCK_I : (i == 1) ? MOSI_I : (i == 2) ? MISO_I : NSS_I;
        sync_q[i] <= meta_q[i];
      end
    end
  end
  assign sck_s = sync_q[0];
  assign mosi_s = sync_q[1];
  assign miso_s = sync_q[2];
  assign nss_s = sync_q[3];

  assign master = master_enable_q;
  assign modf_set = port_enable_q && master && (select_mode_q == 2'b01) && !nss_flt_q;
  assign sl_en = port_enable_q && !master && !((select_mode_q == 2'b01) && nss_s);
  assign nss_fell = nss_prev_q && !nss_s;

  assign s_edge = sl_en && (sck_s != sck_prev_q);
  assign s_lead = s_edge && (sck_s != clock_polarity_sel_q);
  assign s_trail = s_edge && (sck_s == clock_polarity_sel_q);
  assign lead_ev = master ? lnk.lead : s_lead;
  assign trail_ev = master ? lnk.trail : s_trail;
  assign smp_ev = master ? lnk.sample : (clock_phase_sel_q ? s_trail : s_lead);
  assign in_bit = master ? miso_s : mosi_s;

  assign m_load = port_enable_q && master && (mst_state_q == SCC_M_IDLE) && tx_full_q
    && !modf_set;
  assign s_load = port_enable_q && !master && !sh_full_q && tx_full_q && (bitcnt_q == 3'h0);
  assign load = m_load || s_load;
  assign active = master ? (mst_state_q == SCC_M_RUN) : sl_en;
  assign done = active && trail_ev && (bitcnt_q == `SCC_LAST_BIT);
  assign rx_word = smp_ev ? {rxsh_q[6:0], in_bit} : rxsh_q;
  assign busy = master ? (mst_state_q == SCC_M_RUN) :
    (sl_en && ((bitcnt_q != 3'h0) || (sck_s != clock_polarity_sel_q)));

  // divider used only by master clock generator
  assign lnk.run = port_enable_q && master && (mst_state_q == SCC_M_RUN);
  assign lnk.div = clock_divider_value_q;
  assign lnk.cpol = clock_polarity_sel_q;

  scc_sckgen u_sckgen (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .lnk(lnk)
  );

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      master_enable_q <= 1'b0;
      clock_phase_sel_q <= 1'b0;
      clock_polarity_sel_q <= 1'b0;
    end else begin
      if (wr_cfg) begin
        clock_phase_sel_q <= SFR_WDATA_I[`SCC_CFG_CPHA];
        clock_polarity_sel_q <= SFR_WDATA_I[`SCC_CFG_CPOL];
      end
      master_enable_q <= !modf_set && (wr_cfg ? SFR_WDATA_I[`SCC_CFG_MASTER_ENABLE] : master_enable_q);
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      port_enable_q <= 1'b0;
      select_mode_q <= `SCC_RST_SSM;
      {done_q, wcol_q, modf_q, ovr_q} <= 4'h0;
      clock_divider_value_q <= `SCC_RST_CKR;
    end else begin
      port_enable_q <= !modf_set && (wr_ctrl ? SFR_WDATA_I[`SCC_CTL_EN] : port_enable_q);
      if (wr_ctrl) select_mode_q <= SFR_WDATA_I[`SCC_CTL_SSM_HI:`SCC_CTL_SSM_LO];
      done_q <= done || (wr_ctrl ? SFR_WDATA_I[`SCC_CTL_DONE] : done_q);
      wcol_q <= (wr_dat && tx_full_q) || (wr_ctrl ? SFR_WDATA_I[`SCC_CTL_WCOL] : wcol_q);
      modf_q <= modf_set || (wr_ctrl ? SFR_WDATA_I[`SCC_CTL_MODF] : modf_q);
      ovr_q <= (done && !master && rx_full_q) || (wr_ctrl ? SFR_WDATA_I[`SCC_CTL_OVR] : ovr_q);
      if (wr_ckr) clock_divider_value_q <= SFR_WDATA_I;
    end
  end

  // Transmit and receive buffers
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      txbuf_q <= 8'h00;
      tx_full_q <= 1'b0;
      rxbuf_q <= 8'h00;
      rx_full_q <= 1'b0;
    end else begin
      if (wr_dat && !tx_full_q) txbuf_q <= SFR_WDATA_I;
      tx_full_q <= (wr_dat && !tx_full_q) || (tx_full_q && !load);
      if (done && (master || !rx_full_q)) rxbuf_q <= rx_word;
      rx_full_q <= done || (rx_full_q && !rd_dat);
    end
  end

  // Shifting, bit count and master sequence
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I || !port_enable_q) begin
      txsh_q <= 8'h00;
      rxsh_q <= 8'h00;
      out_q <= 1'b0;
      bitcnt_q <= 3'h0;
      mst_state_q <= SCC_M_IDLE;
    end else begin
      if (load) txsh_q <= txbuf_q;
      else if (trail_ev && active) txsh_q <= {txsh_q[6:0], 1'b0};
      if (active) rxsh_q <= rx_word;
      if (load && !clock_phase_sel_q) out_q <= txbuf_q[7];
      else if (active && lead_ev && clock_phase_sel_q) out_q <= txsh_q[7];
      else if (active && trail_ev && !clock_phase_sel_q) out_q <= txsh_q[6];
      if (m_load || (!master && nss_fell)) bitcnt_q <= 3'h0;
      else if (active && trail_ev) bitcnt_q <= bitcnt_q + 3'h1;
      if (m_load) mst_state_q <= SCC_M_RUN;
      else if (done || !master) mst_state_q <= SCC_M_IDLE;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      sh_full_q <= 1'b0;
      shift_reg_empty_q <= 1'b1;
    end else begin
      sh_full_q <= load || (sh_full_q && !done && port_enable_q);
      // Byte end shares its cycle with the last clock edge, so it wins
      if ((done && !tx_full_q) || !port_enable_q) shift_reg_empty_q <= 1'b1;
      else if (load || s_edge) shift_reg_empty_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      sck_prev_q <= 1'b0;
      nss_prev_q <= 1'b1;
      nss_hist_q <= 2'h3;
      nss_flt_q <= 1'b1;
    end else begin
      sck_prev_q <= sck_s;
      nss_prev_q <= nss_s;
      nss_hist_q <= {nss_hist_q[0], nss_s};
      if ((nss_hist_q == {2{nss_s}})) nss_flt_q <= nss_s;
    end
  end

  assign cfg_rd = {busy, master, clock_phase_sel_q, clock_polarity_sel_q, !nss_flt_q, nss_s,
    master || shift_reg_empty_q, master || !rx_full_q};
  assign ctrl_rd = {done_q, wcol_q, modf_q, ovr_q, select_mode_q, !tx_full_q, port_enable_q};
  assign rdata_d = (SFR_ADDR_I == `SCC_ADDR_CFG) ? cfg_rd :
    (SFR_ADDR_I == `SCC_ADDR_CTRL) ? ctrl_rd :
    (SFR_ADDR_I == `SCC_ADDR_CKR) ? clock_divider_value_q :
    (SFR_ADDR_I == `SCC_ADDR_DAT) ? rxbuf_q : 8'h00;

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) rdata_q <= `SCC_RST_CFG;
    else if (SFR_RE_I) rdata_q <= rdata_d;
  end

  // Pin drivers
  assign SFR_RDATA_O = rdata_q;
  assign SCK_O = lnk.sck;
  assign SCK_OE_N_O = !(port_enable_q && master);
  assign MOSI_O = out_q;
  assign MOSI_OE_N_O = !(port_enable_q && master);
  assign MISO_O = out_q;
  assign MISO_OE_N_O = !sl_en;
  assign NSS_O = select_mode_q[0];
  assign NSS_OE_N_O = !(port_enable_q && select_mode_q[1]);

  a_master_status_ones: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    master |-> cfg_rd[1:0] == 2'h3) else $error("empty bits not 1 in master");
  a_slave_selected_filtered: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    $rose(cfg_rd[`SCC_CFG_SLAVE_SELECTED]) |-> $past(!nss_s) && $past(!nss_s, 2))
    else $error("selected bit follows glitch");
  a_busy_on_start: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    m_load |=> busy [*2]) else $error("busy not shown after start");
  a_slave_no_sck: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !master |-> SCK_OE_N_O && !lnk.run) else $error("slave drives clock");
  a_master_idle_sck: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    master && !busy && $past(!busy) && $stable(clock_polarity_sel_q)
    |-> SCK_O == clock_polarity_sel_q) else $error("master clock not idle");
  a_cfg_write_bits: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    wr_cfg && !modf_set |=> master_enable_q == $past(SFR_WDATA_I[6])
    && clock_phase_sel_q == $past(SFR_WDATA_I[5])) else $error("config write lost");
  a_select_output: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    port_enable_q && select_mode_q[1] |-> !NSS_OE_N_O && NSS_O == select_mode_q[0])
    else $error("select output wrong");
  a_slave_mid_sample: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    s_lead && !clock_phase_sel_q |-> smp_ev) else $error("slave sample point");
  a_disabled_quiet: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !port_enable_q |-> SCK_OE_N_O && MOSI_OE_N_O && MISO_OE_N_O && !lnk.run)
    else $error("port off active");
  a_shift_reg_empty_after_byte: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    done && !master && !tx_full_q |=> shift_reg_empty_q)
    else $error("shift empty not set at byte end");
  a_rx_full_set: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    done |=> rx_full_q) else $error("receive data not flagged");

  c_master_byte: cover property (@(posedge CLK_I) disable iff (!RST_N_I) done && master);
  c_slave_byte: cover property (@(posedge CLK_I) disable iff (!RST_N_I) done && !master);
  c_overrun: cover property (@(posedge CLK_I) disable iff (!RST_N_I) $rose(ovr_q));
  c_mode_fault: cover property (@(posedge CLK_I) disable iff (!RST_N_I) modf_set);
  c_three_wire: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
    sl_en && (select_mode_q == 2'b00));
endmodule // scc_top

/* verif/scc_spi_partner.sv */
// Far-side serial device: slave to a master port, or send-only master.
// Assumes the bench resolves the shared pins and sets phase and polarity.
`timescale 1ns/1ps
module scc_spi_partner (
  // Pins seen from the far side
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic nss_n_i,
  output logic miso_o,
  output logic sck_o,
  output logic mosi_o,
  output logic nss_n_o,
  // Bench control
  input wire logic cpol_i,
  input wire logic cpha_i,
  input wire logic slave_en_i,
  input wire logic [7:0] tx_byte_i,
  output logic [7:0] rx_byte_o
);
  logic [7:0] sh_q;
  initial begin
    miso_o = 1'b0;
    sck_o = 1'b0;
    mosi_o = 1'b0;
    nss_n_o = 1'b1;
    rx_byte_o = 8'h00;
    sh_q = 8'h00;
  end
  // Idle clock follows polarity
  always @(cpol_i) if (nss_n_o) sck_o = cpol_i;
  // Load on select, first bit out for phase 0
  always @(negedge nss_n_i) if (slave_en_i) begin
    sh_q = tx_byte_i;
    if (!cpha_i) begin
      miso_o = sh_q[7];
      sh_q = {sh_q[6:0], 1'b0};
    end
  end
  // Released line shows inverse of last bit
  always @(posedge nss_n_i) miso_o = ~miso_o;
  always @(sck_i) if (slave_en_i && !nss_n_i) begin
    if ((sck_i != cpol_i) ^ cpha_i) rx_byte_o = {rx_byte_o[6:0], mosi_i};
    else begin
      miso_o = sh_q[7];
      sh_q = {sh_q[6:0], 1'b0};
    end
  end
  // send-only, eight core cycles per bit
  task automatic send(input logic [7:0] b);
    int i;
    #37;
    nss_n_o = 1'b0;
    if (!cpha_i) mosi_o = b[7];
    #400;
    // Phase 0 data moves on the trailing edge, phase 1 on the leading
    for (i = 7; i >= 0; i--) begin
      sck_o = ~cpol_i;
      if (cpha_i) mosi_o = b[i];
      #200;
      sck_o = cpol_i;
      if (!cpha_i && i > 0) mosi_o = b[i - 1];
      #200;
    end
    #400;
    nss_n_o = 1'b1;
    mosi_o = ~mosi_o;
  endtask
endmodule // scc_spi_partner

/* verif/test_spi_clock_config_status.sv */
// Self-checking bench for the serial port clock, config and status block.
// Assumes the constants header on the include path and the far-side model.
`timescale 1ns/1ps
`include "scc_consts.svh"
module test_spi_clock_config_status;
  import scc_pkg::*;
  typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] e;} scc_row_s;
  logic clk, rst_n, we, re, sck_o, sck_oe_n, mosi_o, mosi_oe_n;
  logic miso_o, miso_oe_n, nss_o, nss_oe_n, sck_prev;
  logic p_sck, p_mosi, p_miso, p_nss, p_cpol, p_cpha, p_sen;
  logic [7:0] addr, p_tx, p_rx;
  scc_byte_t wdata, rdata, got;
  int n_errors, n_checks, run_len, min_half;
  wire sck_w = sck_oe_n ? p_sck : sck_o;
  wire mosi_w = mosi_oe_n ? p_mosi : mosi_o;
  wire miso_w = miso_oe_n ? p_miso : miso_o;
  wire nss_w = nss_oe_n ? p_nss : nss_o;
  scc_row_s rows [6] = '{'{`SCC_ADDR_CFG, 8'hff, 8'h77}, '{`SCC_ADDR_CFG, 8'h00, 8'h07},
    '{`SCC_ADDR_CFG, 8'h30, 8'h37}, '{`SCC_ADDR_CFG, 8'h8f, 8'h07},
    '{8'h55, 8'hff, 8'h00}, '{`SCC_ADDR_CKR, 8'h5a, 8'h5a}};

  scc_top u_scc_top (
    .CLK_I(clk), .RST_N_I(rst_n), .SFR_ADDR_I(addr), .SFR_WE_I(we), .SFR_RE_I(re),
    .SFR_WDATA_I(wdata), .SFR_RDATA_O(rdata), .SCK_I(sck_w), .SCK_O(sck_o),
    .SCK_OE_N_O(sck_oe_n), .MOSI_I(mosi_w), .MOSI_O(mosi_o), .MOSI_OE_N_O(mosi_oe_n),
    .MISO_I(miso_w), .MISO_O(miso_o), .MISO_OE_N_O(miso_oe_n), .NSS_I(nss_w),
    .NSS_O(nss_o), .NSS_OE_N_O(nss_oe_n));

  scc_spi_partner u_scc_spi_partner (
    .sck_i(sck_w), .mosi_i(mosi_w), .nss_n_i(nss_w), .miso_o(p_miso), .sck_o(p_sck),
    .mosi_o(p_mosi), .nss_n_o(p_nss), .cpol_i(p_cpol), .cpha_i(p_cpha),
    .slave_en_i(p_sen), .tx_byte_i(p_tx), .rx_byte_o(p_rx));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Shortest master clock half period
  always @(posedge clk) begin
    if (!sck_oe_n && sck_o !== sck_prev) begin
      if (run_len < min_half) min_half <= run_len;
      run_len <= 1;
    end else run_len <= run_len + 1;
    sck_prev <= sck_o;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    we = 1'b1;
    @(negedge clk);
    we = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    re = 1'b1;
    @(negedge clk);
    re = 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  task automatic results;
    $display("checks %0d, errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wait_done;
    int i;
    got = 8'h00;
    for (i = 0; i < 100 && got[7] !== 1'b1; i++) rd(`SCC_ADDR_CTRL, got);
    if (got[7] !== 1'b1) begin
      n_errors++;
      results();
    end
  endtask

  initial begin
    int m;
    logic [7:0] b;
    rst_n = 1'b0;
    we = 1'b0;
    re = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    {p_cpol, p_cpha, p_sen, p_tx} = 11'h000;
    {n_errors, n_checks, run_len, min_half, sck_prev} = {32'd0, 32'd0, 32'd0, 32'd1000, 1'b0};
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    rd(`SCC_ADDR_CFG, got);
    chk(got, `SCC_RST_CFG);
    chk({7'h0, sck_oe_n}, 8'h01);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, got);
      chk(got, rows[i].e);
    end
    // Master transfers in all four phase and polarity settings
    p_sen = 1'b1;
    for (m = 0; m < 4; m++) begin
      b = 8'h3c + 8'(m);
      p_cpha = m[1];
      p_cpol = m[0];
      p_tx = 8'hc5 ^ b;
      wr(`SCC_ADDR_CTRL, 8'h08);
      wr(`SCC_ADDR_CFG, {2'b01, p_cpha, p_cpol, 4'h0});
      // Phase 1 input changes at the leading edge; leave room for the synchronisers
      wr(`SCC_ADDR_CKR, p_cpha ? 8'h03 : 8'h01);
      wr(`SCC_ADDR_CTRL, 8'h09);
      chk({7'h0, sck_o}, {7'h0, p_cpol});
      chk({6'h0, nss_oe_n, nss_o}, 8'h00);
      wr(`SCC_ADDR_DAT, b);
      repeat (4) @(negedge clk);
      rd(`SCC_ADDR_CFG, got);
      chk({7'h0, got[7]}, 8'h01);
      wait_done();
      chk(p_rx, b);
      rd(`SCC_ADDR_DAT, got);
      chk(got, p_tx);
      rd(`SCC_ADDR_CFG, got);
      chk(got & 8'hf3, {2'b01, p_cpha, p_cpol, 4'h3});
    end
    chk(min_half[7:0], 8'h02);
    wr(`SCC_ADDR_CTRL, 8'h0d);
    chk({6'h0, nss_oe_n, nss_o}, 8'h01);
    // Slave receptions from the far-side master
    p_sen = 1'b0;
    for (m = 0; m < 4; m++) begin
      b = 8'h96 + 8'(m);
      p_cpha = m[1];
      p_cpol = m[0];
      wr(`SCC_ADDR_CTRL, 8'h04);
      wr(`SCC_ADDR_CFG, {2'b00, p_cpha, p_cpol, 4'h0});
      wr(`SCC_ADDR_CKR, 8'hff);
      wr(`SCC_ADDR_CTRL, 8'h05);
      fork
        u_scc_spi_partner.send(b);
        begin
          repeat (40) @(negedge clk);
          rd(`SCC_ADDR_CFG, got);
          chk(got & 8'h8c, 8'h88);
        end
      join
      repeat (8) @(negedge clk);
      rd(`SCC_ADDR_CFG, got);
      chk(got, {2'b00, p_cpha, p_cpol, 4'h6});
      rd(`SCC_ADDR_DAT, got);
      chk(got, b);
      rd(`SCC_ADDR_CFG, got);
      chk({7'h0, got[0]}, 8'h01);
    end
    wr(`SCC_ADDR_DAT, 8'h11);
    rd(`SCC_ADDR_CFG, got);
    chk({7'h0, got[1]}, 8'h00);
    wr(`SCC_ADDR_CTRL, 8'h04);
    rd(`SCC_ADDR_CFG, got);
    chk({7'h0, got[1]}, 8'h01);
    wr(`SCC_ADDR_CTRL, 8'h01);
    chk({7'h0, miso_oe_n}, 8'h00);
    wr(`SCC_ADDR_CTRL, 8'h05);
    chk({7'h0, miso_oe_n}, 8'h01);
    rst_n = 1'b0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    rd(`SCC_ADDR_CFG, got);
    chk(got, `SCC_RST_CFG);
    rd(`SCC_ADDR_CTRL, got);
    chk(got, `SCC_RST_CTRL);
    results();
  end
endmodule // test_spi_clock_config_status
